/* File: src/sltf_dev.sv */
// Transmit end: test patterns, alignment device ID and frame end marks
`timescale 1ns/1ps
module sltf_dev
    import sltf_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic              ce,
    sltf_link_if.dev               link,
    input  wire logic              link_8b10b,
    input  wire logic [DATA_W-1:0] sample_data,
    input  wire logic              sample_valid,
    output logic                   sample_ready
);
    logic [7:0]        test_ctrl;
    logic [7:0]        dev_id;
    logic [7:0]        frame_char;
    sltf_state_e       state;
    logic [3:0]        octet_cnt;
    logic [1:0]        mf_cnt;
    logic [30:0]       prbs;
    logic [7:0]        ramp;
    logic              clk_phase;
    logic [3:0]        rpat_idx;
    logic [DATA_W-1:0] prev_last;
    logic [DATA_W-1:0] fifo_data;
    logic              fifo_valid;
    logic              fifo_pop;
    sltf_test_e        code;
    logic [7:0]        eof_char;
    logic [7:0]        ila_byte;
    logic              ila_k;
    logic              frame_end;
    logic [30:0]       next_prbs;
    logic [7:0]        prbs_byte;
    logic [7:0]        next_byte;
    logic              next_k;
    logic              next_raw;

    // Samples queue here so the source stalls during alignment and tests
    sltf_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .rst       (rst),
        .ce        (ce),
        .in_data   (sample_data),
        .in_valid  (sample_valid),
        .in_ready  (sample_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    // Register writes; upper bits are stored as written and read back
    always_ff @(posedge mclk) begin
        if (rst) begin
            test_ctrl  <= TEST_CTRL_RST;
            dev_id     <= DEV_ID_RST;
            frame_char <= FRAME_CHAR_RST;
        end else if (ce && link.reg_wr) begin
            if (link.reg_addr == TEST_CTRL_ADDR) begin
                test_ctrl <= link.reg_wdata;
            end else if (link.reg_addr == DEV_ID_ADDR) begin
                dev_id <= link.reg_wdata;
            end else if (link.reg_addr == FRAME_CHAR_ADDR) begin
                frame_char <= link.reg_wdata;
            end
        end
    end

    // Read data one cycle after the strobe, zero when unmapped
    always_ff @(posedge mclk) begin
        if (rst) begin
            link.reg_rdata <= 8'h00;
        end else if (ce && link.reg_rd) begin
            if (link.reg_addr == TEST_CTRL_ADDR) begin
                link.reg_rdata <= test_ctrl;
            end else if (link.reg_addr == DEV_ID_ADDR) begin
                link.reg_rdata <= dev_id;
            end else if (link.reg_addr == FRAME_CHAR_ADDR) begin
                link.reg_rdata <= frame_char;
            end else begin
                link.reg_rdata <= 8'h00;
            end
        end
    end

    // Effective test code; reserved codes fall back to sample data
    always_comb begin
        code = sltf_test_e'(test_ctrl[TEST_SEL_MSB:0]);
        case (test_ctrl[TEST_SEL_MSB:0])
            5'h0c, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h17,
            5'h18, 5'h19, 5'h1a, 5'h1b, 5'h1c, 5'h1d, 5'h1e,
            5'h1f: code = TP_OFF;
            5'h07, 5'h08, 5'h09, 5'h10: begin
                if (!link_8b10b) begin
                    code = TP_OFF;
                end
            end
            default: code = sltf_test_e'(test_ctrl[TEST_SEL_MSB:0]);
        endcase
    end

    // Frame end character decode; reserved value acts as zero
    always_comb begin
        case (frame_char[FRAME_END_CHAR_SELECT_MSB:0])
            FC_K28_1: eof_char = K28_1;
            FC_K28_5: eof_char = K28_5;
            default:  eof_char = K28_7;
        endcase
    end

    // Alignment sequence content, device ID in second multiframe
    always_comb begin
        ila_byte = {4'h0, octet_cnt};
        ila_k    = 1'b0;
        if (octet_cnt == 4'h0) begin
            ila_byte = K28_0;
            ila_k    = 1'b1;
        end else if (octet_cnt == MF_LAST) begin
            ila_byte = K28_3;
            ila_k    = 1'b1;
        end else if (mf_cnt == 2'h1 && octet_cnt == 4'h1) begin
            ila_byte = K28_4;
            ila_k    = 1'b1;
        end else if (mf_cnt == 2'h1 && octet_cnt == 4'h2) begin
            ila_byte = dev_id;
        end
    end

    // Eight PRBS steps per octet, polynomial per selector code
    always_comb begin
        int order;
        int tap;
        logic fb;
        order     = 7;
        tap       = 6;
        fb        = 1'b0;
        next_prbs = prbs;
        prbs_byte = 8'h00;
        case (code)
            TP_PRBS9:  begin order = 9;  tap = 5;  end
            TP_PRBS15: begin order = 15; tap = 14; end
            TP_PRBS23: begin order = 23; tap = 18; end
            TP_PRBS31: begin order = 31; tap = 28; end
            default:   begin order = 7;  tap = 6;  end
        endcase
        for (int i = 0; i < 8; i++) begin
            fb        = next_prbs[order-1] ^ next_prbs[tap-1];
            next_prbs = {next_prbs[29:0], fb};
            prbs_byte = {prbs_byte[6:0], fb};
        end
        next_prbs = next_prbs & ((31'h1 << order) - 31'h1);
    end

    assign frame_end = (octet_cnt[1:0] == FRAME_LAST);

    // Lane octet selection; test patterns displace samples
    always_comb begin
        next_byte = K28_5;
        next_k    = 1'b1;
        next_raw  = 1'b0;
        fifo_pop  = 1'b0;
        case (state)
            ST_IDLE: begin
                next_byte = K28_5;
                next_k    = 1'b1;
            end
            ST_ILA: begin
                next_byte = ila_byte;
                next_k    = ila_k;
            end
            default: begin
                next_k = 1'b0;
                case (code)
                    TP_OFF: begin
                        fifo_pop  = fifo_valid;
                        next_byte = fifo_valid ? fifo_data : 8'h00;
                        if (link_8b10b && frame_end &&
                            next_byte == prev_last) begin
                            next_byte = eof_char;
                            next_k    = 1'b1;
                        end
                    end
                    TP_PRBS7, TP_PRBS9, TP_PRBS15, TP_PRBS23,
                    TP_PRBS31: begin
                        next_byte = prbs_byte;
                        next_raw  = 1'b1;
                    end
                    TP_RAMP:      next_byte = ramp;
                    TP_TRANSPORT: next_byte = {octet_cnt, ~octet_cnt};
                    TP_D21_5:     next_byte = D21_5;
                    TP_K28_5: begin
                        next_byte = K28_5;
                        next_k    = 1'b1;
                    end
                    TP_REP_ILA: begin
                        next_byte = ila_byte;
                        next_k    = ila_k;
                    end
                    TP_RPAT: next_byte = RPAT_SEQ[95-8*rpat_idx -: 8];
                    TP_LOW: begin
                        next_byte = 8'h00;
                        next_raw  = 1'b1;
                    end
                    TP_HIGH: begin
                        next_byte = 8'hff;
                        next_raw  = 1'b1;
                    end
                    TP_CLOCK: begin
                        next_byte = clk_phase ? CLK_PATTERN[7:0]
                                              : CLK_PATTERN[15:8];
                        next_raw  = 1'b1;
                    end
                    TP_K28_7: begin
                        next_byte = K28_7;
                        next_k    = 1'b1;
                    end
                    default: next_byte = 8'h00;
                endcase
            end
        endcase
    end

    // Sequencing: comma idle, four alignment multiframes, then data
    always_ff @(posedge mclk) begin
        if (rst) begin
            state     <= ST_IDLE;
            octet_cnt <= 4'h0;
            mf_cnt    <= 2'h0;
        end else if (ce) begin
            if (!link.serial_link_enable) begin
                state     <= ST_IDLE;
                octet_cnt <= 4'h0;
                mf_cnt    <= 2'h0;
            end else begin
                if (state == ST_IDLE) begin
                    state <= ST_ILA;
                end else begin
                    octet_cnt <= octet_cnt + 4'h1;
                    if (octet_cnt == MF_LAST) begin
                        mf_cnt <= mf_cnt + 2'h1;
                        if (state == ST_ILA && mf_cnt == ILA_MF_LAST) begin
                            state <= ST_DATA;
                        end
                    end
                end
            end
        end
    end

    // Pattern generators advance every octet in the data state, whichever pattern is on the lane
    always_ff @(posedge mclk) begin
        if (rst) begin
            prbs      <= PRBS_SEED;
            ramp      <= 8'h00;
            clk_phase <= 1'b0;
            rpat_idx  <= 4'h0;
            prev_last <= 8'h00;
        end else if (ce) begin
            if (state != ST_DATA) begin
                prbs      <= PRBS_SEED;
                ramp      <= 8'h00;
                clk_phase <= 1'b0;
                rpat_idx  <= 4'h0;
            end else begin
                prbs      <= next_prbs;
                ramp      <= ramp + 8'h01;
                clk_phase <= ~clk_phase;
                rpat_idx  <= (rpat_idx == RPAT_LAST) ? 4'h0
                                                     : rpat_idx + 4'h1;
            end
            // Compare against the sample, not the substituted character
            if (state == ST_DATA && frame_end) begin
                prev_last <= fifo_valid ? fifo_data : 8'h00;
            end
        end
    end

    // Registered lane outputs
    always_ff @(posedge mclk) begin
        if (rst) begin
            link.lane_byte  <= 8'h00;
            link.lane_k     <= 1'b0;
            link.lane_raw   <= 1'b0;
            link.lane_valid <= 1'b0;
        end else if (ce) begin
            link.lane_byte  <= next_byte;
            link.lane_k     <= next_k;
            link.lane_raw   <= next_raw;
            link.lane_valid <= link.serial_link_enable;
        end
    end
endmodule

/* File: inc/sltf_pkg.sv */
// Shared constants and types for the serial link test and framing block
package sltf_pkg;

    // Register offsets and field positions
    localparam logic [11:0] TEST_CTRL_ADDR  = 12'h205;
    localparam logic [11:0] DEV_ID_ADDR     = 12'h206;
    localparam logic [11:0] FRAME_CHAR_ADDR = 12'h207;
    localparam int          TEST_SEL_MSB    = 4;
    localparam int          FRAME_END_CHAR_SELECT_MSB       = 1;
    localparam logic [7:0]  TEST_CTRL_RST   = 8'h00;
    localparam logic [7:0]  DEV_ID_RST      = 8'h00;
    localparam logic [7:0]  FRAME_CHAR_RST  = 8'h00;

    // Data path geometry and timing counts
    localparam int          DATA_W     = 8;
    localparam int          FIFO_DEPTH = 4;
    localparam logic [1:0]  FRAME_LAST = 2'h3;  // 4 octets per frame
    localparam logic [3:0]  MF_LAST    = 4'hf;  // 16 octets per multiframe
    localparam logic [1:0]  ILA_MF_LAST = 2'h3; // 4 multiframes of alignment
    localparam logic [3:0]  RPAT_LAST  = 4'hb;  // 12 octet random pattern

    // Control and data characters (8-bit value before 8B/10B encoding) and pattern constants
    localparam logic [7:0] K28_0 = 8'h1c;
    localparam logic [7:0] K28_1 = 8'h3c;
    localparam logic [7:0] K28_3 = 8'h7c;
    localparam logic [7:0] K28_4 = 8'h9c;
    localparam logic [7:0] K28_5 = 8'hbc;
    localparam logic [7:0] K28_7 = 8'hfc;
    localparam logic [7:0] D21_5 = 8'hb5;
    localparam logic [15:0] CLK_PATTERN = 16'h00ff;
    localparam logic [95:0] RPAT_SEQ = 96'hbed723476b8fb3145efb3559;
    localparam logic [30:0] PRBS_SEED = 31'h7fffffff;

    // Test pattern selector codes
    typedef enum logic [4:0] {
        TP_OFF       = 5'h00,
        TP_PRBS7     = 5'h01,
        TP_PRBS15    = 5'h02,
        TP_PRBS23    = 5'h03,
        TP_RAMP      = 5'h04,
        TP_TRANSPORT = 5'h05,
        TP_D21_5     = 5'h06,
        TP_K28_5     = 5'h07,
        TP_REP_ILA   = 5'h08,
        TP_RPAT      = 5'h09,
        TP_LOW       = 5'h0a,
        TP_HIGH      = 5'h0b,
        TP_PRBS9     = 5'h0d,
        TP_PRBS31    = 5'h0e,
        TP_CLOCK     = 5'h0f,
        TP_K28_7     = 5'h10
    } sltf_test_e;

    // Frame end character selector
    typedef enum logic [1:0] {
        FC_K28_7 = 2'h0,
        FC_K28_1 = 2'h1,
        FC_K28_5 = 2'h2
    } sltf_frame_end_char_select_e;

    // Transmit sequencing
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ILA  = 2'b01,
        ST_DATA = 2'b10
    } sltf_state_e;

endpackage

/* File: inc/sltf_link_if.sv */
// Register port and lane stream between device and receiver ends
`timescale 1ns/1ps
interface sltf_link_if (
    input wire logic mclk
);
    import sltf_pkg::*;

    logic              reg_wr;
    logic              reg_rd;
    logic [11:0]       reg_addr;
    logic [7:0]        reg_wdata;
    logic [7:0]        reg_rdata;
    logic              serial_link_enable;
    logic [DATA_W-1:0] lane_byte;
    logic              lane_k;
    logic              lane_raw;
    logic              lane_valid;

    modport dev (
        input  reg_wr, reg_rd, reg_addr, reg_wdata, serial_link_enable,
        output reg_rdata, lane_byte, lane_k, lane_raw, lane_valid
    );
    modport host (
        output reg_wr, reg_rd, reg_addr, reg_wdata, serial_link_enable,
        input  reg_rdata, lane_byte, lane_k, lane_raw, lane_valid
    );
endinterface

/* File: src/sltf_fifo.sv */
// Small sample FIFO with valid and ready on both sides
`timescale 1ns/1ps
module sltf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    // Full and empty straight from the occupancy count
    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign push      = ce & in_valid & in_ready;
    assign pop       = ce & out_valid & out_ready;
    assign out_data  = mem[rd_ptr];

    // Storage, written only on an accepted push
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers wrap at the depth, which need not be a power of two
    always_ff @(posedge mclk) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

/* File: src/sltf_host.sv */
// Receiver end: programs the device and watches the lane stream
`timescale 1ns/1ps
module sltf_host
    import sltf_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic              ce,
    sltf_link_if.host              link,
    input  wire logic              user_link_enable,
    input  wire logic              user_wr,
    input  wire logic              user_rd,
    input  wire logic [11:0]       user_addr,
    input  wire logic [7:0]        user_wdata,
    output logic                   user_done,
    output logic                   user_refused,
    output logic      [7:0]        user_rdata,
    output logic      [DATA_W-1:0] rx_byte,
    output logic                   rx_k,
    output logic                   rx_raw,
    output logic                   rx_valid,
    output logic      [7:0]        rx_dev_id
);
    logic       rd_wait;
    logic       q_seen;
    logic       bad_write;
    logic [7:0] clean_wdata;

    // Upper bits cleared before a test control or frame character write leaves the host
    always_comb begin
        clean_wdata = 8'h00;
        if (user_addr == TEST_CTRL_ADDR) begin
            clean_wdata[TEST_SEL_MSB:0] = user_wdata[TEST_SEL_MSB:0];
        end else if (user_addr == FRAME_CHAR_ADDR) begin
            clean_wdata[FRAME_END_CHAR_SELECT_MSB:0] = user_wdata[FRAME_END_CHAR_SELECT_MSB:0];
        end else begin
            clean_wdata = user_wdata;
        end
    end

    // Reserved selector codes and reserved character
    always_comb begin
        bad_write = 1'b0;
        if (link.serial_link_enable) begin
            // No reconfiguration while the link runs
            bad_write = 1'b1;
        end else if (user_addr == TEST_CTRL_ADDR) begin
            bad_write = (user_wdata[TEST_SEL_MSB:0] == 5'h0c) ||
                        (user_wdata[TEST_SEL_MSB:0] > TP_K28_7);
        end else if (user_addr == FRAME_CHAR_ADDR) begin
            bad_write = (user_wdata[FRAME_END_CHAR_SELECT_MSB:0] == 2'h3);
        end
    end

    // Register strobes, one cycle each; write done with its strobe, read done two cycles later
    always_ff @(posedge mclk) begin
        if (rst) begin
            link.reg_wr    <= 1'b0;
            link.reg_rd    <= 1'b0;
            link.reg_addr  <= 12'h000;
            link.reg_wdata <= 8'h00;
            rd_wait        <= 1'b0;
            user_done      <= 1'b0;
            user_refused   <= 1'b0;
            user_rdata     <= 8'h00;
        end else if (ce) begin
            link.reg_wr  <= 1'b0;
            link.reg_rd  <= 1'b0;
            user_done    <= 1'b0;
            user_refused <= 1'b0;
            rd_wait      <= link.reg_rd;
            if (rd_wait) begin
                user_rdata <= link.reg_rdata;
                user_done  <= 1'b1;
            end
            if (!link.reg_wr && !link.reg_rd && !rd_wait) begin
                if (user_wr && bad_write) begin
                    user_refused <= 1'b1;
                end else if (user_wr) begin
                    link.reg_wr    <= 1'b1;
                    link.reg_addr  <= user_addr;
                    link.reg_wdata <= clean_wdata;
                    user_done      <= 1'b1;
                end else if (user_rd) begin
                    link.reg_rd   <= 1'b1;
                    link.reg_addr <= user_addr;
                end
            end
        end
    end

    // Link enable follows the user level
    always_ff @(posedge mclk) begin
        if (rst) begin
            link.serial_link_enable <= 1'b0;
        end else if (ce) begin
            link.serial_link_enable <= user_link_enable;
        end
    end

    // Lane capture; device ID is the octet after the K28.4 marker
    always_ff @(posedge mclk) begin
        if (rst) begin
            rx_byte   <= 8'h00;
            rx_k      <= 1'b0;
            rx_raw    <= 1'b0;
            rx_valid  <= 1'b0;
            rx_dev_id <= 8'h00;
            q_seen    <= 1'b0;
        end else if (ce) begin
            rx_byte  <= link.lane_byte;
            rx_k     <= link.lane_k;
            rx_raw   <= link.lane_raw;
            rx_valid <= link.lane_valid;
            q_seen   <= link.lane_valid && link.lane_k &&
                        link.lane_byte == K28_4;
            if (q_seen && link.lane_valid && !link.lane_k) begin
                rx_dev_id <= link.lane_byte;
            end
        end
    end
endmodule

/* File: tb/sltf_link_properties.sv */
// Checks on the strobes and lane stream between the two ends
`timescale 1ns/1ps
module sltf_link_properties
    import sltf_pkg::*;
(
    input wire logic              mclk,
    input wire logic              rst,
    input wire logic              reg_wr,
    input wire logic [11:0]       reg_addr,
    input wire logic [7:0]        reg_wdata,
    input wire logic              serial_link_enable,
    input wire logic [DATA_W-1:0] lane_byte,
    input wire logic              lane_k,
    input wire logic              lane_raw,
    input wire logic              lane_valid
);
    logic [7:0] code_q;
    logic [7:0] id_q;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Copy of stored settings; exact only because writes wait for idle
    always_ff @(posedge mclk) begin
        if (rst) begin
            code_q <= 8'h00;
            id_q   <= 8'h00;
        end else if (reg_wr) begin
            if (reg_addr == TEST_CTRL_ADDR) code_q <= reg_wdata;
            if (reg_addr == DEV_ID_ADDR) id_q <= reg_wdata;
        end
    end
    property p_wr_off; reg_wr |-> !serial_link_enable; endproperty
    a_wr_off: assert property (p_wr_off) else $error("write while on");
    property p_code;
        reg_wr && reg_addr == TEST_CTRL_ADDR |-> reg_wdata[7:5] == 3'h0 &&
            reg_wdata[4:0] != 5'h0c && reg_wdata[4:0] <= 5'h10;
    endproperty
    a_code: assert property (p_code) else $error("bad test code");
    property p_frame_end_char_select;
        reg_wr && reg_addr == FRAME_CHAR_ADDR |-> reg_wdata <= 8'h02;
    endproperty
    a_frame_end_char_select: assert property (p_frame_end_char_select) else $error("bad frame char");
    property p_start;
        $rose(serial_link_enable) |-> ##[1:2] (lane_k && lane_byte == K28_0);
    endproperty
    a_start: assert property (p_start) else $error("no alignment");
    property p_id; lane_k && lane_byte == K28_4 |=> lane_byte == id_q; endproperty
    a_id: assert property (p_id) else $error("wrong device id");
    property p_off; lane_valid && code_q == 8'h00 |-> !lane_raw; endproperty
    a_off: assert property (p_off) else $error("raw in normal mode");
    property p_level;
        lane_raw && code_q[7:1] == 7'h05 |-> lane_byte == {8{code_q[0]}};
    endproperty
    a_level: assert property (p_level) else $error("level wrong");
    property p_clock;
        lane_valid && lane_raw && code_q == 8'h0f ##1 lane_raw |->
            lane_byte == ~$past(lane_byte);
    endproperty
    a_clock: assert property (p_clock) else $error("clock pattern");
    property p_raw;
        lane_valid && lane_raw |-> code_q inside {8'h01, 8'h02, 8'h03,
            8'h0a, 8'h0b, 8'h0d, 8'h0e, 8'h0f};
    endproperty
    a_raw: assert property (p_raw) else $error("raw octet");
    c_id: cover property (lane_k && lane_byte == K28_4);
    c_level: cover property (lane_raw && code_q == 8'h0b);
    c_clock: cover property (lane_raw && code_q == 8'h0f);
endmodule

/* File: tb/serdes_link_test_and_framing_config_tb.sv */
// Bench joining both link ends, table driven pattern runs
`timescale 1ns/1ps
module serdes_link_test_and_framing_config_tb
    import sltf_pkg::*;
;
    typedef struct packed {logic [7:0] wd; logic m8; logic rf;
        logic [7:0] rb; logic [9:0] ln; logic cl;} sltf_row_s;
    logic        mclk, rst, link_8b10b, sample_valid, sample_ready, rf, ce;
    logic        user_link_enable, user_wr, user_rd, user_done, user_refused;
    logic        rx_k, rx_raw, rx_valid;
    logic [7:0]  sample_data, user_wdata, user_rdata, rx_byte, rx_dev_id;
    logic [11:0] user_addr;
    logic [7:0]  fc[3] = '{K28_7, K28_1, K28_5};
    int          fails = 0, n_checks = 0, r, f, i, nk;
    // Code, 8B/10B, refused, read back, {raw,k,octet}, lane checked
    sltf_row_s   rows[10] = '{
        '{8'h0b, 1'h1, 1'h0, 8'h0b, 10'h2ff, 1'h1},
        '{8'h0a, 1'h1, 1'h0, 8'h0a, 10'h200, 1'h1},
        '{8'h0c, 1'h1, 1'h1, 8'h0a, 10'h200, 1'h1},
        '{8'h11, 1'h1, 1'h1, 8'h0a, 10'h200, 1'h1},
        '{8'he6, 1'h1, 1'h0, 8'h06, 10'h0b5, 1'h1},
        '{8'h07, 1'h1, 1'h0, 8'h07, 10'h1bc, 1'h1},
        '{8'h07, 1'h0, 1'h0, 8'h07, 10'h000, 1'h1},
        '{8'h10, 1'h1, 1'h0, 8'h10, 10'h1fc, 1'h1},
        '{8'h0f, 1'h1, 1'h0, 8'h0f, 10'h200, 1'h1},
        '{8'h00, 1'h0, 1'h0, 8'h00, 10'h000, 1'h1}};
    // 20 MHz clock
    initial begin
        mclk = 1'h0;
        forever #25 mclk = ~mclk;
    end
    // Both ends face each other and share one clock enable
    sltf_link_if lk (.mclk);
    sltf_dev sltf_dev_inst (.mclk, .rst, .ce, .link(lk), .link_8b10b,
        .sample_data, .sample_valid, .sample_ready);
    sltf_host sltf_host_inst (.mclk, .rst, .ce, .link(lk),
        .user_link_enable, .user_wr, .user_rd, .user_addr, .user_wdata,
        .user_done, .user_refused, .user_rdata, .rx_byte, .rx_k, .rx_raw,
        .rx_valid, .rx_dev_id);
    sltf_link_properties sltf_link_properties_inst (.mclk, .rst,
        .reg_wr(lk.reg_wr), .reg_addr(lk.reg_addr), .reg_wdata(lk.reg_wdata),
        .serial_link_enable(lk.serial_link_enable), .lane_k(lk.lane_k),
        .lane_byte(lk.lane_byte), .lane_raw(lk.lane_raw),
        .lane_valid(lk.lane_valid));
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Request held until done or refused, then one idle edge
    task automatic xfer(input logic wr, input logic [11:0] a,
        input logic [7:0] d);
        int k;
        {user_wr, user_rd, user_addr, user_wdata} = {wr, !wr, a, d};
        for (k = 0; k < 8 && !(user_done === 1'h1 || user_refused === 1'h1);
            k++) begin
            @(posedge mclk);
            #1;
        end
        if (k == 8) begin
            fails++;
            $display("wrong value at %0t: no answer", $time);
            summarize();
        end
        rf = user_refused;
        {user_wr, user_rd} = 2'h0;
        @(posedge mclk);
        #1;
    endtask
    task automatic link(input logic on, input int n);
        user_link_enable = on;
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // Main sequence
    initial begin
        {rst, link_8b10b, sample_valid, user_link_enable} = 4'h8;
        ce = 1'h1;
        {user_wr, user_rd, user_addr, user_wdata, sample_data} = 30'h42;
        repeat (10) @(posedge mclk);
        #1 rst = 1'h0;
        for (i = 0; i < 4; i++) begin
            xfer(1'h0, TEST_CTRL_ADDR + 12'(i), 8'h00);
            chk({2'h0, user_rdata}, 10'h000);
        end
        xfer(1'h1, DEV_ID_ADDR, 8'h5a);
        for (r = 0; r < 10; r++) begin
            xfer(1'h1, TEST_CTRL_ADDR, rows[r].wd);
            chk({9'h0, rf}, {9'h0, rows[r].rf});
            xfer(1'h0, TEST_CTRL_ADDR, 8'h00);
            chk({2'h0, user_rdata}, {2'h0, rows[r].rb});
            link_8b10b = rows[r].m8;
            link(1'h1, 72);
            if (rows[r].cl) chk({rx_raw, rx_k, rx_byte}, rows[r].ln);
            link(1'h0, 4);
        end
        chk({2'h0, rx_dev_id}, 10'h05a);
        // Buffer fills while idle, then repeated samples earn frame marks
        sample_valid = 1'h1;
        link(1'h0, 6);
        chk({9'h0, sample_ready}, 10'h000);
        link_8b10b = 1'h1;
        for (f = 0; f < 3; f++) begin
            xfer(1'h1, FRAME_CHAR_ADDR, 8'(f));
            link(1'h1, 72);
            nk = 0;
            for (i = 0; i < 8; i++) begin
                nk += int'(rx_k === 1'h1);
                chk({2'h0, rx_byte}, rx_k ? {2'h0, fc[f]} : 10'h042);
                link(1'h1, 1);
            end
            chk(10'(nk), 10'h002);
            link(1'h0, 4);
        end
        sample_valid = 1'h0;
        // Buffer drains only once alignment is over
        link(1'h1, 72);
        chk({9'h0, sample_ready}, 10'h001);
        xfer(1'h1, DEV_ID_ADDR, 8'h33);
        chk({9'h0, rf}, 10'h001);
        link(1'h0, 4);
        xfer(1'h0, DEV_ID_ADDR, 8'h00);
        chk({2'h0, user_rdata}, 10'h05a);
        // Enable low freezes both ends; idle comma must stay put
        ce = 1'h0;
        link(1'h1, 8);
        chk({2'h0, rx_byte}, {2'h0, K28_5});
        ce = 1'h1;
        link(1'h0, 2);
        summarize();
    end
endmodule
